// ---- rtl/dsimc_regs.vh ----
`ifndef DSIMC_REGS_VH
`define DSIMC_REGS_VH

// Command codes, taken as {cs_n, ras_n, cas_n, we_n}; any code with cs_n high is a deselect.
`define DSIMC_CMD_MRS 4'h0
`define DSIMC_CMD_REF 4'h1
`define DSIMC_CMD_PRE 4'h2
`define DSIMC_CMD_ACT 4'h3
`define DSIMC_CMD_WR 4'h4
`define DSIMC_CMD_RD 4'h5
`define DSIMC_CMD_NOP 4'h7

// Bank address values that select the mode registers.
`define DSIMC_BA_MODE 2'h0
`define DSIMC_BA_EXT 2'h1

// Field positions in the operating mode register.
`define DSIMC_BL_LSB 0
`define DSIMC_BL_MSB 2
`define DSIMC_BT_BIT 3
`define DSIMC_CL_LSB 4
`define DSIMC_CL_MSB 6
`define DSIMC_OPM_LSB 7
`define DSIMC_OPM_MSB 11
`define DSIMC_DLL_RST_BIT 8

// Field positions in the extended mode register and the precharge-all address bit.
`define DSIMC_EXT_DLL_DIS_BIT 0
`define DSIMC_PRE_ALL_BIT 10

// Field encodings.
`define DSIMC_BL2 3'h1
`define DSIMC_BL4 3'h2
`define DSIMC_BL8 3'h3
`define DSIMC_CL2 3'h2
`define DSIMC_CL25 3'h6
`define DSIMC_OPM_NORMAL 5'h00
`define DSIMC_OPM_DLL_RST 5'h02

// Reset values.
`define DSIMC_MODE_RST 12'h000
`define DSIMC_EXT_RST 12'h000

// Clocks from a DLL reset until read data timing is trusted (200 cycles).
`define DSIMC_DLL_LOCK_CYC 8'hC8

`endif

// ---- rtl/dsimc_pair_buf.v ----
`timescale 1ns/1ps

// Two-entry buffer with valid and ready on both sides.
module dsimc_pair_buf #(
    parameter W = 9
) (
    input wire sys_clk,
    input wire nrst,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] slot_r [0:1];
    reg [1:0] cnt_r;
    reg rd_r;
    reg wr_r;
    wire push;
    wire pop;

    // Full and empty come straight from the count, so a stall cannot overrun the store.
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = slot_r[rd_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointers and count.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            cnt_r <= 2'h0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
        end else begin
            if (push) begin
                wr_r <= ~wr_r;
            end
            if (pop) begin
                rd_r <= ~rd_r;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 2'h1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end

    // Storage needs no reset; nothing reads a slot before it is written.
    always @(posedge sys_clk) begin
        if (push) begin
            slot_r[wr_r] <= in_data;
        end
    end
endmodule // dsimc_pair_buf

// ---- rtl/dsimc_core.v ----
`timescale 1ns/1ps
`include "dsimc_regs.vh"

// Behaviour
// - Reads and writes need an open row in their bank, opened by activate.
// - Activate takes bank from the bank inputs and row from A0-A11.
// - Read or write takes the burst start column from the address inputs.
// - One double-width array word per clock, split into two half-cycle pin beats.
// - Data and strobe outputs stay undriven until a read drives them.
// - Mode programming outside a write burst never disturbs stored array contents.
// - Mode programming leaves the refresh address counter unchanged.
// - Bank bits zero write the base register; its DLL reset bit self-clears.
// - Fields: burst length A0-A2, type A3, latency A4-A6, mode A7-A11.
// - Burst lengths 2, 4 and 8, sequential or interleaved.
// - Bursts wrap inside an aligned block of burst-length columns.
// - Burst length bounds the columns one read or write command touches.
// - The one burst length applies to reads and writes alike.
// - Read latency is 2 or 2.5 clocks from command to first data.
// - Mode field with only A8 set resets the DLL; all zero is normal.
// - Bank bit 0 set, bit 1 clear writes the extended mode register.
module dsimc_core #(
    parameter DQ_W = 4,
    parameter COL_W = 10,
    parameter ROW_W = 12,
    parameter MEM_ROW_W = 2
) (
    input wire sys_clk,
    input wire nrst,
    input wire cke,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [1:0] ba,
    input wire [ROW_W-1:0] addr,
    input wire [DQ_W-1:0] dq_rise_i,
    input wire [DQ_W-1:0] dq_fall_i,
    input wire dm_rise,
    input wire dm_fall,
    input wire dqs_i,
    input wire rdq_ready,
    output reg [DQ_W-1:0] dq_rise_o,
    output reg [DQ_W-1:0] dq_fall_o,
    output reg dq_oe,
    output reg dqs_rise_o,
    output reg dqs_fall_o,
    output reg dqs_oe,
    output reg init_ready,
    output reg dll_locked,
    output reg [ROW_W-1:0] refresh_row
);
    localparam AW = 2 + MEM_ROW_W + COL_W;
    localparam BW = 2 * DQ_W + 1;

    // Initialisation progress, advanced by the controller's command sequence.
    localparam ST_PRE1 = 3'h0;
    localparam ST_EMRS = 3'h1;
    localparam ST_MRS_RST = 3'h2;
    localparam ST_PRE2 = 3'h3;
    localparam ST_REF1 = 3'h4;
    localparam ST_REF2 = 3'h5;
    localparam ST_MRS_NORM = 3'h6;
    localparam ST_READY = 3'h7;

    // Last index within a burst, from the burst length code.
    function [2:0] bl_last;
        input [2:0] code;
        begin
            case (code)
                `DSIMC_BL2: bl_last = 3'h1;
                `DSIMC_BL4: bl_last = 3'h3;
                `DSIMC_BL8: bl_last = 3'h7;
                default: bl_last = 3'h1;
            endcase
        end
    endfunction

    // Column of beat k; the low bits wrap inside the block, the high bits stay put.
    function [COL_W-1:0] beat_col;
        input [COL_W-1:0] start;
        input [2:0] k;
        input [2:0] mask;
        input inter;
        reg [2:0] lo;
        begin
            lo = inter ? (start[2:0] ^ k) : (start[2:0] + k);
            beat_col = (start & ~{{(COL_W-3){1'b0}}, mask}) | {{(COL_W-3){1'b0}}, lo & mask};
        end
    endfunction

    // Flat array index of one location.
    function [AW-1:0] mem_idx;
        input [1:0] bank;
        input [MEM_ROW_W-1:0] row;
        input [COL_W-1:0] col;
        begin
            mem_idx = {bank, row, col};
        end
    endfunction

    reg [DQ_W-1:0] mem_r [0:(1<<AW)-1];
    reg [ROW_W-1:0] row_r [0:3];
    reg [3:0] open_r;
    reg [11:0] mode_r;
    reg [11:0] ext_r;
    reg [2:0] state_r;
    reg [7:0] dll_cnt_r;
    reg busy_r;
    reg wr_r;
    reg [2:0] k_r;
    reg [COL_W-1:0] wcol_r;
    reg [1:0] wbank_r;
    reg [MEM_ROW_W-1:0] wrow_r;
    reg [DQ_W-1:0] hold_r;
    reg tail_r;
    reg act_r;
    integer i;

    wire [3:0] cmd;
    wire [2:0] blm1;
    wire [2:0] k_next;
    wire inter;
    wire half;
    wire last;
    wire [AW-1:0] idx0;
    wire [AW-1:0] idx1;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [BW-1:0] buf_out_data;
    wire step;
    wire pop;
    wire is_mode;
    wire is_ext;

    // Commands count only while clock enable is high; a deselect matches no code.
    assign cmd = cke ? {cs_n, ras_n, cas_n, we_n} : `DSIMC_CMD_NOP;
    assign is_mode = (cmd == `DSIMC_CMD_MRS) && (ba == `DSIMC_BA_MODE);
    assign is_ext = (cmd == `DSIMC_CMD_MRS) && (ba == `DSIMC_BA_EXT);

    // Burst shape comes from the single programmed length, for reads and writes.
    assign blm1 = bl_last(mode_r[`DSIMC_BL_MSB:`DSIMC_BL_LSB]);
    assign inter = mode_r[`DSIMC_BT_BIT];
    assign half = (mode_r[`DSIMC_CL_MSB:`DSIMC_CL_LSB] == `DSIMC_CL25);
    assign k_next = k_r + 3'h1;
    assign last = (k_next == blm1);

    // Two columns per clock form one double-width array word.
    assign idx0 = mem_idx(wbank_r, wrow_r, beat_col(wcol_r, k_r, blm1, inter));
    assign idx1 = mem_idx(wbank_r, wrow_r, beat_col(wcol_r, k_next, blm1, inter));

    // A read step waits for buffer room; a write step never stalls.
    assign step = busy_r && (wr_r || buf_in_ready);
    assign pop = buf_out_valid && rdq_ready;

    // The buffer holds read pairs so that a stall at the pins loses no word.
    dsimc_pair_buf #(
        .W(BW)
    ) u_buf (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(busy_r && !wr_r),
        .in_ready(buf_in_ready),
        .in_data({last, mem_r[idx1], mem_r[idx0]}),
        .out_valid(buf_out_valid),
        .out_ready(rdq_ready),
        .out_data(buf_out_data)
    );

    // Row bookkeeping, mode registers and burst walker; later writes win over the walker.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            open_r <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                row_r[i] <= {ROW_W{1'b0}};
            end
            mode_r <= `DSIMC_MODE_RST;
            ext_r <= `DSIMC_EXT_RST;
            busy_r <= 1'b0;
            wr_r <= 1'b0;
            k_r <= 3'h0;
            wcol_r <= {COL_W{1'b0}};
            wbank_r <= 2'h0;
            wrow_r <= {MEM_ROW_W{1'b0}};
            refresh_row <= {ROW_W{1'b0}};
        end else begin
            // The DLL reset bit is a one-shot request and drops the clock after it lands.
            if (mode_r[`DSIMC_DLL_RST_BIT]) begin
                mode_r[`DSIMC_DLL_RST_BIT] <= 1'b0;
            end
            if (step) begin
                if (last) begin
                    busy_r <= 1'b0;
                end else begin
                    k_r <= k_r + 3'h2;
                end
            end
            case (cmd)
                `DSIMC_CMD_ACT: begin
                    open_r[ba] <= 1'b1;
                    row_r[ba] <= addr;
                end
                `DSIMC_CMD_PRE: begin
                    if (addr[`DSIMC_PRE_ALL_BIT]) begin
                        open_r <= 4'h0;
                    end else begin
                        open_r[ba] <= 1'b0;
                    end
                end
                `DSIMC_CMD_RD, `DSIMC_CMD_WR: begin
                    // An access to a closed bank is dropped; a new one cuts a running burst.
                    if (open_r[ba]) begin
                        busy_r <= 1'b1;
                        wr_r <= (cmd == `DSIMC_CMD_WR);
                        k_r <= 3'h0;
                        wcol_r <= addr[COL_W-1:0];
                        wbank_r <= ba;
                        wrow_r <= row_r[ba][MEM_ROW_W-1:0];
                    end
                end
                `DSIMC_CMD_MRS: begin
                    // Only the mode registers change; array and refresh counter are untouched.
                    if (is_mode) begin
                        mode_r <= addr;
                    end else if (is_ext) begin
                        ext_r <= addr;
                    end
                end
                `DSIMC_CMD_REF: begin
                    refresh_row <= refresh_row + {{(ROW_W-1){1'b0}}, 1'b1};
                end
                default: begin
                end
            endcase
        end
    end

    // Write beats arrive one clock after the command; masked halves keep old data.
    always @(posedge sys_clk) begin
        if (busy_r && wr_r) begin
            if (!dm_rise) begin
                mem_r[idx0] <= dq_rise_i;
            end
            if (!dm_fall) begin
                mem_r[idx1] <= dq_fall_i;
            end
        end
    end

    // DLL lock timer restarts on every DLL reset; an extended write with the DLL disable bit set clears it.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            dll_cnt_r <= 8'h00;
            dll_locked <= 1'b0;
        end else if (is_mode && (addr[`DSIMC_OPM_MSB:`DSIMC_OPM_LSB] == `DSIMC_OPM_DLL_RST)) begin
            dll_cnt_r <= `DSIMC_DLL_LOCK_CYC;
            dll_locked <= 1'b0;
        end else if (is_ext && addr[`DSIMC_EXT_DLL_DIS_BIT]) begin
            dll_cnt_r <= 8'h00;
            dll_locked <= 1'b0;
        end else if (dll_cnt_r != 8'h00) begin
            dll_cnt_r <= dll_cnt_r - 8'h01;
            dll_locked <= (dll_cnt_r == 8'h01) && !ext_r[`DSIMC_EXT_DLL_DIS_BIT];
        end
    end

    // Tracks the power-up sequence; out-of-order commands simply do not advance it.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            state_r <= ST_PRE1;
            init_ready <= 1'b0;
        end else begin
            init_ready <= (state_r == ST_READY);
            case (state_r)
                ST_PRE1: begin
                    if (cmd == `DSIMC_CMD_PRE && addr[`DSIMC_PRE_ALL_BIT]) begin
                        state_r <= ST_EMRS;
                    end
                end
                ST_EMRS: begin
                    if (is_ext && !addr[`DSIMC_EXT_DLL_DIS_BIT]) begin
                        state_r <= ST_MRS_RST;
                    end
                end
                ST_MRS_RST: begin
                    if (is_mode && addr[`DSIMC_OPM_MSB:`DSIMC_OPM_LSB] == `DSIMC_OPM_DLL_RST) begin
                        state_r <= ST_PRE2;
                    end
                end
                ST_PRE2: begin
                    if (cmd == `DSIMC_CMD_PRE && addr[`DSIMC_PRE_ALL_BIT]) begin
                        state_r <= ST_REF1;
                    end
                end
                ST_REF1: begin
                    if (cmd == `DSIMC_CMD_REF) begin
                        state_r <= ST_REF2;
                    end
                end
                ST_REF2: begin
                    if (cmd == `DSIMC_CMD_REF) begin
                        state_r <= ST_MRS_NORM;
                    end
                end
                ST_MRS_NORM: begin
                    if (is_mode && addr[`DSIMC_OPM_MSB:`DSIMC_OPM_LSB] == `DSIMC_OPM_NORMAL) begin
                        state_r <= ST_READY;
                    end
                end
                default: begin
                    state_r <= ST_READY;
                end
            endcase
        end
    end

    // Pin stage. At latency 2.5 every beat slides half a clock: the rising slot carries
    // the previous pair's second beat, so the burst needs one extra trailing clock.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            dq_rise_o <= {DQ_W{1'b0}};
            dq_fall_o <= {DQ_W{1'b0}};
            dq_oe <= 1'b0;
            dqs_rise_o <= 1'b0;
            dqs_fall_o <= 1'b0;
            dqs_oe <= 1'b0;
            hold_r <= {DQ_W{1'b0}};
            tail_r <= 1'b0;
            act_r <= 1'b0;
        end else if (pop) begin
            dq_oe <= 1'b1;
            dqs_oe <= 1'b1;
            act_r <= !buf_out_data[BW-1];
            if (half) begin
                dq_rise_o <= act_r ? hold_r : {DQ_W{1'b0}};
                dq_fall_o <= buf_out_data[DQ_W-1:0];
                hold_r <= buf_out_data[2*DQ_W-1:DQ_W];
                tail_r <= buf_out_data[BW-1];
                dqs_rise_o <= 1'b0;
                dqs_fall_o <= 1'b1;
            end else begin
                dq_rise_o <= buf_out_data[DQ_W-1:0];
                dq_fall_o <= buf_out_data[2*DQ_W-1:DQ_W];
                tail_r <= 1'b0;
                dqs_rise_o <= 1'b1;
                dqs_fall_o <= 1'b0;
            end
        end else if (tail_r) begin
            dq_rise_o <= hold_r;
            dq_fall_o <= {DQ_W{1'b0}};
            dq_oe <= 1'b1;
            dqs_oe <= 1'b1;
            dqs_rise_o <= 1'b0;
            dqs_fall_o <= 1'b1;
            tail_r <= 1'b0;
            act_r <= 1'b0;
        end else begin
            // Outside a read the pins are released; a stalled burst also releases them.
            dq_oe <= 1'b0;
            dqs_oe <= 1'b0;
            dqs_rise_o <= 1'b0;
            dqs_fall_o <= 1'b0;
        end
    end
endmodule // dsimc_core

// ---- test/dsimc_core_asserts.sv ----
`timescale 1ns/1ps
`include "dsimc_regs.vh"

// Port checks of the core; open banks and latency are shadowed from the command stream.
module dsimc_core_chk #(
    parameter DQ_W = 4,
    parameter ROW_W = 12
) (
    input wire sys_clk,
    input wire nrst,
    input wire cke,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [1:0] ba,
    input wire [ROW_W-1:0] addr,
    input wire rdq_ready,
    input wire [DQ_W-1:0] dq_rise_o,
    input wire dq_oe,
    input wire dqs_rise_o,
    input wire dqs_oe,
    input wire init_ready,
    input wire dll_locked,
    input wire [ROW_W-1:0] refresh_row
);
    reg [3:0] open_r;
    reg [2:0] cl_r;
    reg [7:0] age_r;
    reg [5:0] rd_age_r;
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire ref_t = cke && cmd == `DSIMC_CMD_REF;
    wire mrs_t = cke && cmd == `DSIMC_CMD_MRS;
    wire rd_ok = cke && cmd == `DSIMC_CMD_RD && open_r[ba];
    wire norm_t = mrs_t && ba == `DSIMC_BA_MODE && addr[11:7] == 5'h00;
    wire dllr_t = mrs_t && ba == `DSIMC_BA_MODE && addr[11:7] == 5'h02;

    // Ages saturate, so a long idle spell never wraps back into a small value.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            open_r <= 4'h0;
            cl_r <= 3'h0;
            age_r <= 8'h00;
            rd_age_r <= 6'h3F;
        end else begin
            if (cke && cmd == `DSIMC_CMD_ACT) begin
                open_r[ba] <= 1'b1;
            end
            if (cke && cmd == `DSIMC_CMD_PRE) begin
                open_r <= addr[10] ? 4'h0 : open_r & ~(4'h1 << ba);
            end
            if (mrs_t && ba == `DSIMC_BA_MODE) begin
                cl_r <= addr[6:4];
            end
            age_r <= dllr_t ? 8'h00 : age_r + {7'h00, age_r != 8'hFF};
            rd_age_r <= rd_ok ? 6'h00 : rd_age_r + {5'h00, rd_age_r != 6'h3F};
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    strobe_with_data_a: assert property (dq_oe
        |-> dqs_oe && dqs_rise_o == (cl_r != `DSIMC_CL25))
        else $error("read data driven without strobe");
    data_needs_read_a: assert property ($rose(dq_oe) |-> rd_age_r < 6'h28)
        else $error("read data without a read to an open bank");
    ref_step_a: assert property (ref_t |=> refresh_row == $past(refresh_row) + 1'b1)
        else $error("refresh counter did not step");
    mode_keeps_refresh_a: assert property (mrs_t |=> $stable(refresh_row))
        else $error("mode write moved refresh counter");
    gated_ref_a: assert property (!cke && cmd == `DSIMC_CMD_REF |=> $stable(refresh_row))
        else $error("refresh taken with clock enable low");
    dll_reset_drop_a: assert property (dllr_t |-> ##[1:2] !dll_locked)
        else $error("lock kept over DLL reset");
    dll_off_drop_a: assert property (mrs_t && ba == `DSIMC_BA_EXT && addr[0] |-> ##[1:2] !dll_locked)
        else $error("lock kept with DLL disabled");
    dll_lock_wait_a: assert property ($rose(dll_locked) |-> age_r >= 8'hC8)
        else $error("lock reported too early");
    ready_after_norm_a: assert property ($rose(init_ready) |-> $past(norm_t) || $past(norm_t, 2))
        else $error("ready without closing mode write");
    cl2_first_a: assert property (rd_ok && cl_r == `DSIMC_CL2 ##1 rdq_ready [*2] |=> dq_oe)
        else $error("latency 2 data late");
    cl25_first_a: assert property (rd_ok && cl_r == `DSIMC_CL25 ##1 rdq_ready [*2]
        |=> dq_oe && dq_rise_o == 0)
        else $error("latency 2.5 first slot wrong");

    cover property (rd_ok && cl_r == `DSIMC_CL25);
    cover property ($rose(dll_locked));
    cover property (!rdq_ready && !dq_oe && rd_age_r < 6'h08);
endmodule // dsimc_core_chk

bind dsimc_core dsimc_core_chk #(.DQ_W(DQ_W), .ROW_W(ROW_W)) chk_u (.sys_clk(sys_clk),
    .nrst(nrst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .rdq_ready(rdq_ready), .dq_rise_o(dq_rise_o), .dq_oe(dq_oe),
    .dqs_rise_o(dqs_rise_o), .dqs_oe(dqs_oe), .init_ready(init_ready),
    .dll_locked(dll_locked), .refresh_row(refresh_row));

// ---- test/dsimc_ctrl_bfm.sv ----
`timescale 1ns/1ps
`include "dsimc_regs.vh"

// Controller stand-in; pins change only just after a rising edge.
module dsimc_ctrl_bfm (
    input wire sys_clk,
    output reg cke,
    output reg [3:0] cmd,
    output reg [1:0] ba,
    output reg [11:0] addr,
    output reg [3:0] wr_r,
    output reg [3:0] wr_f,
    output reg dm_r,
    output reg dm_f,
    output reg rdq_ready = 1'b1
);
    reg slow = 1'b0;
    reg gate = 1'b0;
    reg [2:0] sc = 3'h0;
    time dll_t = 0;

    // Slow mode stalls four clocks in eight, long enough to fill the read buffer.
    always @(posedge sys_clk) begin
        sc <= sc + 3'h1;
        rdq_ready <= !slow || sc[2];
    end

    // Pins at time zero; write data starts masked.
    initial begin
        cke = 1'b0;
        cmd = `DSIMC_CMD_NOP;
        ba = 2'h0;
        addr = 12'h000;
        wr_r = 4'h0;
        wr_f = 4'h0;
        dm_r = 1'b1;
        dm_f = 1'b1;
    end

    task put(input [3:0] c, input [1:0] b, input [11:0] a);
        @(posedge sys_clk);
        cke <= ~gate;
        cmd <= c;
        ba <= b;
        addr <= a;
    endtask

    // One write pair; released address lines toggle so stale values never look valid.
    task pair(input [3:0] r, input [3:0] f, input mr, input mf);
        @(posedge sys_clk);
        cmd <= {addr[0], 3'h7};
        addr <= ~addr;
        ba <= ~ba;
        wr_r <= r;
        wr_f <= f;
        dm_r <= mr;
        dm_f <= mf;
    endtask

    task idle(input integer n);
        repeat (n) pair(~wr_r, ~wr_f, 1'b1, 1'b1);
    endtask

    // Power-up order; 20000 clocks is 200 us at 100 MHz.
    task init(input [11:0] mode);
        repeat (20000) @(posedge sys_clk);
        cke <= 1'b1;
        idle(1);
        put(`DSIMC_CMD_PRE, 2'h0, 12'h400);
        idle(2);
        put(`DSIMC_CMD_MRS, `DSIMC_BA_EXT, 12'h000);
        idle(2);
        put(`DSIMC_CMD_MRS, `DSIMC_BA_MODE, mode | 12'h100);
        dll_t = $time;
        idle(2);
        put(`DSIMC_CMD_PRE, 2'h0, 12'h400);
        put(`DSIMC_CMD_REF, 2'h0, 12'h000);
        idle(2);
        put(`DSIMC_CMD_REF, 2'h0, 12'h000);
        idle(2);
        put(`DSIMC_CMD_MRS, `DSIMC_BA_MODE, mode);
        idle(2);
    endtask
endmodule // dsimc_ctrl_bfm

// ---- test/tb.sv ----
`timescale 1ns/1ps
`include "dsimc_regs.vh"

module tb;
    reg sys_clk = 1'b0;
    reg nrst = 1'b0;
    reg dqs_i = 1'b0;
    reg ign = 1'b0;
    wire cke, dm_r, dm_f, rdq_ready, dq_oe, dqs_rise_o, dqs_fall_o, dqs_oe, init_ready, dll_locked;
    wire [3:0] cmd, wr_r, wr_f, dq_rise_o, dq_fall_o;
    wire [1:0] ba;
    wire [11:0] addr, refresh_row;
    integer err_count = 0;
    integer check_count = 0;
    reg [31:0] rng = 32'h0000005E;
    reg [3:0] mem [0:16383];
    reg [1:0] orow [0:3];

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) dqs_i <= rng[0];

    dsimc_ctrl_bfm bfm (.sys_clk(sys_clk), .cke(cke), .cmd(cmd), .ba(ba), .addr(addr),
        .wr_r(wr_r), .wr_f(wr_f), .dm_r(dm_r), .dm_f(dm_f), .rdq_ready(rdq_ready));
    dsimc_core dut_u (.sys_clk(sys_clk), .nrst(nrst), .cke(cke), .cs_n(cmd[3]), .ras_n(cmd[2]),
        .cas_n(cmd[1]), .we_n(cmd[0]), .ba(ba), .addr(addr), .dq_rise_i(wr_r), .dq_fall_i(wr_f),
        .dm_rise(dm_r), .dm_fall(dm_f), .dqs_i(dqs_i), .rdq_ready(rdq_ready),
        .dq_rise_o(dq_rise_o), .dq_fall_o(dq_fall_o), .dq_oe(dq_oe), .dqs_rise_o(dqs_rise_o),
        .dqs_fall_o(dqs_fall_o), .dqs_oe(dqs_oe), .init_ready(init_ready),
        .dll_locked(dll_locked), .refresh_row(refresh_row));

    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    // Column of beat k: the burst wraps inside its aligned block of bl columns.
    function [9:0] bcol(input [9:0] st, input integer k, input integer bl, input it);
        reg [9:0] m;
        begin
            m = 10'(bl - 1);
            bcol = (st & ~m) | ((it ? st ^ 10'(k) : st + 10'(k)) & m);
        end
    endfunction

    function [13:0] key(input [1:0] b, input [9:0] c);
        key = {b, orow[b], c};
    endfunction

    task chk(input [11:0] got, input [11:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Mode changes close all banks first, since programming needs every bank idle.
    task mode(input [11:0] m);
        bfm.put(`DSIMC_CMD_PRE, 2'h0, 12'h400);
        bfm.put(`DSIMC_CMD_MRS, `DSIMC_BA_MODE, m);
        bfm.idle(2);
    endtask

    task act(input [1:0] b, input [11:0] r);
        orow[b] = r[1:0];
        bfm.put(`DSIMC_CMD_ACT, b, r);
        bfm.idle(2);
    endtask

    task wr(input [1:0] b, input [9:0] st, input integer bl, input it, input msk);
        integer k;
        reg [1:0] m;
        bfm.put(`DSIMC_CMD_WR, b, {2'h0, st});
        for (k = 0; k < bl; k = k + 2) begin
            rng = xs(rng);
            m = msk ? rng[9:8] : 2'h0;
            bfm.pair(rng[3:0], rng[7:4], m[0], m[1]);
            if (!m[0] && !ign) mem[key(b, bcol(st, k, bl, it))] = rng[3:0];
            if (!m[1] && !ign) mem[key(b, bcol(st, k + 1, bl, it))] = rng[7:4];
        end
        bfm.idle(2);
    endtask

    // Every driven slot is collected; latency 2.5 adds a leading zero and a trailing slot.
    task rd(input [1:0] b, input [9:0] st, input integer bl, input it, input c25);
        reg [3:0] q [$];
        integer k;
        q = {};
        bfm.put(`DSIMC_CMD_RD, b, {2'h0, st});
        fork
            bfm.idle(bl + 30);
            repeat (bl + 30) begin
                @(negedge sys_clk);
                if (dq_oe === 1'b1) begin
                    q.push_back(dq_rise_o);
                    q.push_back(dq_fall_o);
                end
            end
        join
        chk(12'(q.size()), ign ? 12'h000 : 12'(bl + 2 * c25));
        if (c25 && !ign) chk(q.pop_front(), 12'h000);
        for (k = 0; k < bl && !ign; k++) chk(q[k], mem[key(b, bcol(st, k, bl, it))]);
    endtask

    // Ample margin over the roughly 21000 clocks the sequence needs.
    initial begin
        #1000000;
        err_count = err_count + 1;
        $display("MISMATCH t=%0t watchdog expired", $time);
        test_done;
    end

    initial begin : main
        integer i, bl, it, cyc;
        reg [9:0] st;
        reg [11:0] rr;
        reg [1:0] b;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        chk(dq_oe, 12'h000);
        chk(refresh_row, 12'h000);
        $display("test reset done");
        bfm.init(12'h022);
        @(negedge sys_clk);
        chk(init_ready, 12'h001);
        chk(refresh_row, 12'h002);
        for (i = 0; i < 400 && dll_locked !== 1'b1; i++) @(negedge sys_clk);
        cyc = ($time - bfm.dll_t) / 10;
        chk(12'(cyc >= 201 && cyc <= 202), 12'h001);
        $display("test init done");
        for (i = 0; i < 6; i++) begin
            bl = 2 << (i % 3);
            it = i / 3;
            mode({5'h00, `DSIMC_CL2, it[0], 3'(i % 3 + 1)});
            bfm.slow = (i == 5);
            rng = xs(rng);
            b = rng[13:12];
            rr = rng[11:0];
            st = rng[23:14];
            act(b, rr);
            wr(b, st, bl, it, 1'b0);
            rd(b, st, bl, it, 1'b0);
            rd(b, st ^ (10'(bl - 1) & rng[9:0]), bl, it, 1'b0);
            bfm.slow = 1'b0;
        end
        $display("test burst modes done");
        wr(b, st, 8, 1'b1, 1'b1);
        cyc = refresh_row;
        mode(12'h022);
        bfm.put(`DSIMC_CMD_MRS, `DSIMC_BA_EXT, 12'h000);
        bfm.idle(2);
        chk(refresh_row, 12'(cyc));
        act(b, rr);
        rd(b, st, 4, 1'b0, 1'b0);
        mode(12'h062);
        act(b, rr);
        rd(b, st, 4, 1'b0, 1'b1);
        $display("test mode change done");
        bfm.put(`DSIMC_CMD_PRE, b, 12'h000);
        ign = 1'b1;
        wr(b, st, 4, 1'b0, 1'b0);
        rd(b, st, 4, 1'b0, 1'b0);
        ign = 1'b0;
        act(b, rr);
        rd(b, st, 4, 1'b0, 1'b1);
        cyc = refresh_row;
        bfm.gate = 1'b1;
        bfm.put(`DSIMC_CMD_REF, 2'h0, 12'h000);
        bfm.gate = 1'b0;
        bfm.put(`DSIMC_CMD_REF, 2'h0, 12'h000);
        bfm.idle(2);
        chk(refresh_row, 12'(cyc + 1));
        $display("test closed bank and refresh done");
        mode(12'h122);
        chk(dll_locked, 12'h000);
        bfm.put(`DSIMC_CMD_MRS, `DSIMC_BA_EXT, 12'h001);
        bfm.idle(220);
        chk(dll_locked, 12'h000);
        $display("test dll control done");
        test_done;
    end
endmodule // tb
